// File: common/duplex_symbol_encoder_defines.vh
`ifndef DUPLEX_SYMBOL_ENCODER_DEFINES_VH
`define DUPLEX_SYMBOL_ENCODER_DEFINES_VH

// System clock rate in Hz (4 ns period).
`define CLK_HZ            64'd250000000
// Line modulation rate in baud.
`define BAUD_HZ           64'd2400
// System clock cycles per signal element, rounded down.
`define SYM_CYCLES        (`CLK_HZ / `BAUD_HZ)
// Transmit carrier frequency in Hz.
`define CARRIER_HZ        64'd1800
// Largest receive carrier offset the receive oscillator follows, in Hz.
`define RX_OFFSET_MAX_HZ  7
// Width of the carrier phase accumulators.
`define NCO_W             32
// Phase step per clock for the carrier and for one hertz of offset.
`define CARRIER_INC       ((`CARRIER_HZ * 64'h100000000) / `CLK_HZ)
`define HZ_INC            ((64'h100000000 + (`CLK_HZ / 64'd2)) / `CLK_HZ)
// Bits per group at each data rate.
`define BITS_HIGH_RATE    3'd4
`define BITS_LOW_RATE     3'd2
// Fixed third and fourth bits that pick the four-point subset at the low rate.
`define LOW_RATE_Q34      2'b00
// Depth and address width of the transmit bit buffer.
`define TX_FIFO_DEPTH     32
`define TX_FIFO_AW        5
// Reset values of the differential and convolutional state.
`define DIFF_RESET        2'b00
`define CONV_RESET        3'b000

`endif

// File: logic/bit_fifo.v
// Small synchronous FIFO with valid and ready on both sides.
module bit_fifo #(
  parameter WIDTH = 1,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  // Clock and reset.
  input  wire             clk_sys_i,
  input  wire             nrst_i,
  // Write side.
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // Read side.
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o,
  // Clear on restart of transmission.
  input  wire             flush_i
);

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            push;
  wire            pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready_o  = (count_reg != DEPTH[AW:0]);
  assign out_valid_o = (count_reg != {(AW+1){1'b0}});
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Storage has no reset; only the pointers and the count define what is valid.
  always @(posedge clk_sys_i)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= in_data_i;
  end

  // Pointers wrap naturally because the depth is a power of two.
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end
    else if (flush_i)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      if (push && !pop)
        count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
      else if (pop && !push)
        count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
    end
  end

endmodule

// File: logic/duplex_symbol_encoder.v
// Behaviour
// - One signal element per 2400 baud period.
// - Single 1800 Hz carrier, no pilot tone.
// - Receive carrier follows offsets up to 7 Hz.
// - Rates 9600 or 4800 only, never 2400.
// - Uncoded 16 points always; trellis optional.
// - Transmit and receive share one data rate.
// - High rate: four-bit groups, first two earliest.
// - Uncoded: four bits select one of 16.
// - Trellis: first two bits differentially encoded too.
// - Trellis: convolutional encoder makes one parity bit.
// - Trellis: parity plus four bits pick 32.
// - Low rate: two-bit groups, four-point subset.
// - Negotiated rate and coding settle before data.
// - Quadrant index advances by 0,1,2,3 steps.
// - Trellis differential rule with previous outputs.
// - Coordinates follow the published point mapping.
`include "duplex_symbol_encoder_defines.vh"

module duplex_symbol_encoder #(
  parameter SYM_CYCLES       = `SYM_CYCLES,
  parameter TRELLIS_SUPPORT  = 1
) (
  // Clock and reset.
  input  wire              clk_sys_i,
  input  wire              nrst_i,
  // Negotiated operating point, taken at start_i.
  input  wire              start_i,
  input  wire              stop_i,
  input  wire              rate_high_i,
  input  wire              trellis_i,
  // Scrambled serial bit stream.
  input  wire              bit_valid_i,
  input  wire              bit_data_i,
  output wire              bit_ready_o,
  // Signal element output.
  output reg               sym_valid_o,
  output reg  [3:0]        sym_re_o,
  output reg  [3:0]        sym_im_o,
  output reg               underrun_o,
  // Status shared with the receive path.
  output reg               running_o,
  output reg               rate_high_o,
  output reg               trellis_o,
  // Carrier phases.
  input  wire [3:0]        rx_offset_hz_i,
  output wire [15:0]       tx_carrier_phase_o,
  output wire [15:0]       rx_carrier_phase_o
);

  localparam [63:0] CARRIER_INC64 = `CARRIER_INC;
  localparam [63:0] HZ_INC64      = `HZ_INC;
  localparam [63:0] SYM_LAST64    = SYM_CYCLES - 1;
  localparam [31:0] CARRIER_INC   = CARRIER_INC64[31:0];
  localparam [31:0] HZ_INC        = HZ_INC64[31:0];
  localparam [16:0] SYM_LAST      = SYM_LAST64[16:0];
  localparam        TRELLIS_OK    = (TRELLIS_SUPPORT != 0);
  localparam [31:0] OFF_MIN32     = -`RX_OFFSET_MAX_HZ;

  // Operating states.
  localparam [1:0] ST_IDLE  = 2'd0;
  localparam [1:0] ST_RUN   = 2'd1;

  reg  [1:0]  state_reg;
  reg  [16:0] baud_cnt_reg;
  reg  [3:0]  group_reg;
  reg  [2:0]  fill_reg;
  reg  [1:0]  diff_reg;
  reg  [2:0]  conv_reg;
  reg  [31:0] tx_nco_reg;
  reg  [31:0] rx_nco_reg;
  wire        fifo_valid;
  wire        fifo_data;
  wire        fifo_ready;
  wire        baud_tick;
  wire [2:0]  need_bits;
  wire        group_full;

  // Differential quadrant coding: index order 00,01,11,10; step from the input pair.
  function [1:0] diff_quadrant;
    input [1:0] q;
    input [1:0] prev;
    reg   [1:0] idx;
    reg   [1:0] step;
    begin
      idx           = {prev[1], prev[1] ^ prev[0]};
      step          = {q[1], q[1] ^ ~q[0]};
      idx           = idx + step;
      diff_quadrant = {idx[1], idx[1] ^ idx[0]};
    end
  endfunction

  // Differential rule for the trellis alternative; bits are {first, second}.
  function [1:0] diff_trellis;
    input [1:0] q;
    input [1:0] prev;
    begin
      diff_trellis = {q[1] ^ prev[1], (q[1] & prev[1]) ^ prev[0] ^ q[0]};
    end
  endfunction

  // Uncoded map, index {high, low, third, fourth}, result {re, im} two's complement.
  function [7:0] map_uncoded;
    input [3:0] idx;
    begin
      case (idx)
        4'h0: map_uncoded = 8'hff;
        4'h1: map_uncoded = 8'hdf;
        4'h2: map_uncoded = 8'hfd;
        4'h3: map_uncoded = 8'hdd;
        4'h4: map_uncoded = 8'h1f;
        4'h5: map_uncoded = 8'h1d;
        4'h6: map_uncoded = 8'h3f;
        4'h7: map_uncoded = 8'h3d;
        4'h8: map_uncoded = 8'hf1;
        4'h9: map_uncoded = 8'hf3;
        4'ha: map_uncoded = 8'hd1;
        4'hb: map_uncoded = 8'hd3;
        4'hc: map_uncoded = 8'h11;
        4'hd: map_uncoded = 8'h31;
        4'he: map_uncoded = 8'h13;
        default: map_uncoded = 8'h33;
      endcase
    end
  endfunction

  // Trellis map, index {parity, high, low, third, fourth}.
  function [7:0] map_trellis;
    input [4:0] idx;
    begin
      case (idx)
        5'h00: map_trellis = 8'hc1;
        5'h01: map_trellis = 8'h0d;
        5'h02: map_trellis = 8'h01;
        5'h03: map_trellis = 8'h41;
        5'h04: map_trellis = 8'h4f;
        5'h05: map_trellis = 8'h03;
        5'h06: map_trellis = 8'h0f;
        5'h07: map_trellis = 8'hcf;
        5'h08: map_trellis = 8'he3;
        5'h09: map_trellis = 8'hef;
        5'h0a: map_trellis = 8'h23;
        5'h0b: map_trellis = 8'h2f;
        5'h0c: map_trellis = 8'h2d;
        5'h0d: map_trellis = 8'h21;
        5'h0e: map_trellis = 8'hed;
        5'h0f: map_trellis = 8'he1;
        5'h10: map_trellis = 8'hde;
        5'h11: map_trellis = 8'h1e;
        5'h12: map_trellis = 8'hd2;
        5'h13: map_trellis = 8'h12;
        5'h14: map_trellis = 8'h32;
        5'h15: map_trellis = 8'hf2;
        5'h16: map_trellis = 8'h3e;
        5'h17: map_trellis = 8'hfe;
        5'h18: map_trellis = 8'h14;
        5'h19: map_trellis = 8'hd0;
        5'h1a: map_trellis = 8'h10;
        5'h1b: map_trellis = 8'h1c;
        5'h1c: map_trellis = 8'hfc;
        5'h1d: map_trellis = 8'h30;
        5'h1e: map_trellis = 8'hf0;
        default: map_trellis = 8'hf4;
      endcase
    end
  endfunction

  // Next state of the eight-state systematic feedback encoder; parity is state bit 0.
  function [2:0] conv_next;
    input [2:0] s;
    input [1:0] y;
    begin
      conv_next = {s[0], s[2] ^ y[1] ^ y[0], s[1] ^ y[0]};
    end
  endfunction

  // Bits arrive through a buffer so the source sees honest back-pressure.
  bit_fifo #(
    .WIDTH (1),
    .DEPTH (`TX_FIFO_DEPTH),
    .AW    (`TX_FIFO_AW)
  ) u_bit_fifo (
    .clk_sys_i   (clk_sys_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (bit_valid_i),
    .in_ready_o  (bit_ready_o),
    .in_data_i   (bit_data_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_ready),
    .out_data_o  (fifo_data),
    .flush_i     (start_i)
  );

  // Group size follows the latched rate; only the two documented rates exist.
  assign need_bits  = rate_high_o ? `BITS_HIGH_RATE : `BITS_LOW_RATE;
  assign group_full = (fill_reg == need_bits);
  assign baud_tick  = (state_reg == ST_RUN) && (baud_cnt_reg == SYM_LAST);
  // The group is not topped up in the tick cycle, so a tick sees a stable group.
  assign fifo_ready = (state_reg == ST_RUN) && !group_full && !baud_tick;

  // Operating point is fixed from the start of a transmission until it is restarted.
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_reg   <= ST_IDLE;
      running_o   <= 1'b0;
      rate_high_o <= 1'b0;
      trellis_o   <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (start_i)
          begin
            state_reg   <= ST_RUN;
            running_o   <= 1'b1;
            rate_high_o <= rate_high_i;
            trellis_o   <= rate_high_i && trellis_i && TRELLIS_OK;
          end
        end
        ST_RUN:
        begin
          if (stop_i)
          begin
            state_reg <= ST_IDLE;
            running_o <= 1'b0;
          end
          else if (start_i)
          begin
            rate_high_o <= rate_high_i;
            trellis_o   <= rate_high_i && trellis_i && TRELLIS_OK;
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
          running_o <= 1'b0;
        end
      endcase
    end
  end

  // Baud counter restarts with every start so the first element lands one period and one cycle later.
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      baud_cnt_reg <= 17'h00000;
    else if (start_i || state_reg != ST_RUN || baud_tick)
      baud_cnt_reg <= 17'h00000;
    else
      baud_cnt_reg <= baud_cnt_reg + 17'h00001;
  end

  // Serial bits fill the group in time order: bit 0 is the first in time.
  // A short group at a tick is kept and topped up later, so an underrun loses no data.
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      group_reg <= 4'h0;
      fill_reg  <= 3'd0;
    end
    else if (start_i || (baud_tick && group_full))
    begin
      fill_reg <= 3'd0;
      if (start_i)
        group_reg <= 4'h0;
    end
    else if (fifo_valid && fifo_ready)
    begin
      group_reg[fill_reg[1:0]] <= fifo_data;
      fill_reg                 <= fill_reg + 3'd1;
    end
  end

  // Encode one group per tick; on a short group the previous element is repeated.
  always @(posedge clk_sys_i or negedge nrst_i)
  begin : encode
    reg [1:0] q12;
    reg [1:0] y12;
    reg [1:0] q34;
    reg [7:0] pt;
    if (!nrst_i)
    begin
      diff_reg    <= `DIFF_RESET;
      conv_reg    <= `CONV_RESET;
      sym_valid_o <= 1'b0;
      sym_re_o    <= 4'h0;
      sym_im_o    <= 4'h0;
      underrun_o  <= 1'b0;
    end
    else
    begin
      q12 = {group_reg[0], group_reg[1]};
      q34 = rate_high_o ? {group_reg[2], group_reg[3]} : `LOW_RATE_Q34;
      y12 = trellis_o ? diff_trellis(q12, diff_reg) : diff_quadrant(q12, diff_reg);
      if (trellis_o)
        pt = map_trellis({conv_reg[0], y12, q34});
      else
        pt = map_uncoded({y12, q34});
      sym_valid_o <= baud_tick;
      underrun_o  <= baud_tick && !group_full;
      if (start_i)
      begin
        diff_reg <= `DIFF_RESET;
        conv_reg <= `CONV_RESET;
      end
      else if (baud_tick && group_full)
      begin
        diff_reg <= y12;
        if (trellis_o)
          conv_reg <= conv_next(conv_reg, y12);
        sym_re_o <= pt[7:4];
        sym_im_o <= pt[3:0];
      end
    end
  end

  // Carrier oscillators; the transmit one is a single tone with nothing added.
  always @(posedge clk_sys_i or negedge nrst_i)
  begin : carrier
    reg signed [4:0] off;
    reg        [31:0] step;
    if (!nrst_i)
    begin
      tx_nco_reg <= 32'h00000000;
      rx_nco_reg <= 32'h00000000;
    end
    else
    begin
      off = {rx_offset_hz_i[3], rx_offset_hz_i};
      // An offset of -8 is beyond the tracked range and is clamped.
      if (off < $signed(OFF_MIN32[4:0]))
        off = OFF_MIN32[4:0];
      step       = CARRIER_INC + ({{27{off[4]}}, off} * HZ_INC);
      tx_nco_reg <= tx_nco_reg + CARRIER_INC;
      rx_nco_reg <= rx_nco_reg + step;
    end
  end

  assign tx_carrier_phase_o = tx_nco_reg[31:16];
  assign rx_carrier_phase_o = rx_nco_reg[31:16];

endmodule

// File: test/duplex_symbol_encoder_chk.sv
module duplex_symbol_encoder_chk #(
  parameter int SYM_CYCLES = 16
) (
  // Clock, reset and controls.
  input logic        clk_sys_i,
  input logic        nrst_i,
  input logic        start_i,
  input logic        stop_i,
  input logic        rate_high_i,
  input logic        trellis_i,
  // Outputs watched.
  input logic        sym_valid_o,
  input logic [3:0]  sym_re_o,
  input logic [3:0]  sym_im_o,
  input logic        underrun_o,
  input logic        running_o,
  input logic        rate_high_o,
  input logic        trellis_o,
  input logic [15:0] tx_carrier_phase_o,
  input logic [15:0] rx_carrier_phase_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] cnt_reg;
  logic        first_reg;
  logic [3:0]  age_reg;
  wire  [31:0] due_w = first_reg ? SYM_CYCLES + 1 : SYM_CYCLES;

  // The first element after a restart lands one cycle later than the steady period.
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_reg   <= 32'h0;
      first_reg <= 1'b0;
      age_reg   <= 4'h0;
    end
    else
    begin
      cnt_reg   <= start_i ? 32'h1 : (sym_valid_o ? 32'h1 : cnt_reg + 32'h1);
      first_reg <= start_i | (first_reg & ~sym_valid_o);
      age_reg   <= (age_reg == 4'hf) ? age_reg : age_reg + 4'h1;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  period_a: assert property (sym_valid_o |-> cnt_reg == due_w)
    else $error("element off its period");
  due_a: assert property (running_o && cnt_reg == due_w |-> sym_valid_o)
    else $error("element missing");
  repeat_a: assert property (underrun_o |-> sym_valid_o && $stable({sym_re_o, sym_im_o}))
    else $error("underrun element not repeated");
  hold_a: assert property (!sym_valid_o |-> $stable({sym_re_o, sym_im_o}))
    else $error("coordinates moved between elements");
  latch_a: assert property (start_i && !stop_i |=> running_o
    && rate_high_o == $past(rate_high_i)
    && trellis_o == ($past(trellis_i) && $past(rate_high_i)))
    else $error("operating point not latched");
  stop_a: assert property (stop_i && running_o |=> !running_o ##1 !sym_valid_o [*8])
    else $error("element after stop");
  tx_carrier_a: assert property (age_reg == 4'hf |->
    16'(tx_carrier_phase_o - $past(tx_carrier_phase_o, 8)) inside {16'h3, 16'h4})
    else $error("transmit carrier rate wrong");
  rx_carrier_a: assert property (age_reg == 4'hf |->
    16'(rx_carrier_phase_o - $past(rx_carrier_phase_o, 8)) inside {16'h3, 16'h4})
    else $error("receive carrier rate wrong");

  cover property (sym_valid_o && trellis_o);
  cover property (sym_valid_o && !rate_high_o);
  cover property (underrun_o);
endmodule

bind duplex_symbol_encoder duplex_symbol_encoder_chk #(.SYM_CYCLES(SYM_CYCLES)) chk_inst (
  .clk_sys_i, .nrst_i, .start_i, .stop_i, .rate_high_i, .trellis_i, .sym_valid_o, .sym_re_o,
  .sym_im_o, .underrun_o, .running_o, .rate_high_o, .trellis_o, .tx_carrier_phase_o,
  .rx_carrier_phase_o
);

// File: test/scrambled_bit_source.sv
module scrambled_bit_source (
  // Clock and pacing.
  input  wire logic clk_sys_i,
  input  wire logic enable_i,
  input  wire logic stall_i,
  input  wire logic bit_ready_i,
  // Offered bit.
  output logic      bit_valid_o,
  output logic      bit_data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  integer seed = 74327;
  logic   en, st, taken;

  // A bit stands until taken; a released line toggles so no stale value can be mistaken for data.
  initial
  begin
    bit_valid_o = 1'b0;
    bit_data_o  = 1'b0;
    forever
    begin
      @(posedge clk_sys_i);
      taken = bit_valid_o && bit_ready_i;
      en    = enable_i;
      st    = stall_i;
      #1;
      if (taken || !bit_valid_o)
      begin
        bit_valid_o = en && !(st && 1'($random(seed)));
        bit_data_o  = bit_valid_o ? 1'($random(seed)) : ~bit_data_o;
      end
    end
  end
endmodule

// File: test/tb_duplex_symbol_encoder.sv
module tb_duplex_symbol_encoder;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SYM = 16;
  localparam logic [127:0] TRE = 128'hff3f_11d1_f3f3_1d1d_ee22_22ee_c004_400c;
  localparam logic [127:0] TIM = 128'h400c_c004_ee22_22ee_1d1d_f3f3_ff3f_11d1;
  logic        clk_sys_i, nrst_i, start_i, stop_i, rate_high_i, trellis_i, src_en, src_stall;
  logic        bit_valid_i, bit_data_i, bit_ready_o, sym_valid_o, underrun_o;
  logic        running_o, rate_high_o, trellis_o, hi, tr;
  logic [3:0]  sym_re_o, sym_im_o, rx_offset_hz_i;
  logic [15:0] tx_carrier_phase_o, rx_carrier_phase_o;
  logic [1:0]  d;
  logic [2:0]  s;
  logic [7:0]  last = 8'h00;
  logic        q[$];
  integer      seed = 74327;
  int          err_count = 0, n_compared = 0, n_sym = 0, n_under = 0, k;

  duplex_symbol_encoder #(.SYM_CYCLES(SYM), .TRELLIS_SUPPORT(1)) duplex_symbol_encoder_inst (
    .clk_sys_i, .nrst_i, .start_i, .stop_i, .rate_high_i, .trellis_i, .bit_valid_i,
    .bit_data_i, .bit_ready_o, .sym_valid_o, .sym_re_o, .sym_im_o, .underrun_o, .running_o,
    .rate_high_o, .trellis_o, .rx_offset_hz_i, .tx_carrier_phase_o, .rx_carrier_phase_o);
  scrambled_bit_source scrambled_bit_source_inst (.clk_sys_i, .enable_i(src_en),
    .stall_i(src_stall), .bit_ready_i(bit_ready_o), .bit_valid_o(bit_valid_i),
    .bit_data_o(bit_data_i));

  // Point map: the uncoded grid is built from quadrant and magnitude bits, trellis from a table.
  function automatic logic [7:0] point(input logic [4:0] i, input logic t);
    logic [3:0] a, b, r, m;
    a = i[0] ? 4'h3 : 4'h1;
    b = i[1] ? 4'h3 : 4'h1;
    r = (i[3] ^ i[2]) ? b : a;
    m = (i[3] ^ i[2]) ? a : b;
    if (t)
      return {TRE[i*4 +: 4], TIM[i*4 +: 4]};
    return {i[2] ? r : -r, i[3] ? m : -m};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want)
    begin
      err_count++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Reference encoder: pops one group per full element and advances its own state.
  task automatic take_symbol();
    logic b1, b2, b3, b4, e1, e2, par;
    logic [1:0] pos;
    n_sym++;
    if (underrun_o)
    begin
      n_under++;
      check({sym_re_o, sym_im_o}, last);
      return;
    end
    if (q.size() < (hi ? 4 : 2))
    begin
      check(8'h00, 8'hff);
      return;
    end
    b1 = q.pop_front();
    b2 = q.pop_front();
    b3 = hi ? q.pop_front() : 1'b0;
    b4 = hi ? q.pop_front() : 1'b0;
    par = s[0];
    if (tr)
    begin
      e1 = b1 ^ d[1];
      e2 = (b1 & d[1]) ^ d[0] ^ b2;
      s = {s[0], s[2] ^ e1 ^ e2, s[1] ^ e2};
    end
    else
    begin
      pos = {d[1], d[1] ^ d[0]} + {b1, ~(b1 ^ b2)};
      e1 = pos[1];
      e2 = pos[1] ^ pos[0];
      par = 1'b0;
    end
    d = {e1, e2};
    last = point({par, e1, e2, b3, b4}, tr);
    check({sym_re_o, sym_im_o}, last);
  endtask

  // Monitor sees inputs and outputs as they stood just before each edge.
  always @(posedge clk_sys_i)
  begin
    if (nrst_i && sym_valid_o)
      take_symbol();
    if (!nrst_i || start_i)
    begin
      q.delete();
      hi = rate_high_i;
      tr = trellis_i & rate_high_i;
      d = 2'b00;
      s = 3'b000;
    end
    else if (bit_valid_i && bit_ready_o)
      q.push_back(bit_data_i);
  end

  task automatic drive(input logic st, input logic sp, input logic rh, input logic t);
    @(posedge clk_sys_i);
    #1;
    start_i = st;
    stop_i = sp;
    rate_high_i = rh;
    trellis_i = t;
  endtask

  // Restart at a new operating point, which is usually while already running.
  task automatic run_mode(input logic rh, input logic t);
    drive(1'b1, 1'b0, rh, t);
    drive(1'b0, 1'b0, rh, t);
    check({5'h0, rate_high_o, trellis_o, running_o}, {5'h0, rh, rh & t, 1'b1});
    rx_offset_hz_i = 4'($random(seed) % 8);
    repeat (12 * SYM) @(posedge clk_sys_i);
  endtask

  initial
  begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  initial
  begin
    #100000;
    err_count++;
    wrap_up();
  end

  initial
  begin
    {nrst_i, start_i, stop_i, rate_high_i, trellis_i, src_en, src_stall} = 7'h0;
    rx_offset_hz_i = 4'h0;
    repeat (4) @(posedge clk_sys_i);
    #1 nrst_i = 1'b1;
    src_en = 1'b1;
    repeat (40) @(posedge clk_sys_i);
    #1 check(8'(q.size()), 8'd32);
    check({7'h0, bit_ready_o}, 8'h00);
    for (int m = 0; m < 4; m++)
      run_mode(~m[1], m[0]);
    // Pacing changes off the edge so the source never races its own sampling.
    #1 src_stall = 1'b1;
    repeat (6) run_mode(1'($random(seed)), 1'($random(seed)));
    #1 src_stall = 1'b0;
    src_en = 1'b0;
    // The gap outlasts a full buffer at either rate, so underruns must occur.
    repeat (24 * SYM) @(posedge clk_sys_i);
    #1 src_en = 1'b1;
    repeat (6 * SYM) @(posedge clk_sys_i);
    check({7'h0, n_under != 0}, 8'h01);
    drive(1'b0, 1'b1, 1'b1, 1'b0);
    drive(1'b0, 1'b0, 1'b1, 1'b0);
    k = n_sym;
    repeat (4 * SYM) @(posedge clk_sys_i);
    #1 check(8'(n_sym - k), 8'h00);
    check({7'h0, running_o}, 8'h00);
    wrap_up();
  end
endmodule
